// file: verilog/fcu_top.sv
/*
  Convert and compare unit: integer to double, double to integer, ordered and
  unordered compare, with status register and condition field updates.
  Assumes the issue logic holds instruction and operands until done.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fcu_cfg.svh"

module fcu_top #(
  parameter bit IMPL_64 = 1'b1
) (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        issue_valid,
  input  wire logic [31:0] issue_instr,
  input  wire logic [63:0] operand_a,
  input  wire logic [63:0] operand_b,
  input  wire logic        status_wr,
  input  wire logic [31:0] status_wr_data,
  output logic             done,
  output logic             illegal_instr,
  output logic             target_we,
  output logic [4:0]       target_index,
  output logic [63:0]      target_data,
  output logic             cr_we,
  output logic [2:0]       cr_slot,
  output logic [3:0]       cr_data,
  output logic [31:0]      fp_status_control
);
  import fcu_pkg::*;

  // --------------------------------------------------------------------------
  // Decode and compare helpers
  // --------------------------------------------------------------------------
  function automatic fcu_op_t decode(input logic [31:0] ins);
    decode = FCU_OP_NONE;
    if (ins[31:26] == `FCU_PRIMARY) begin
      unique case (ins[10:1])
        `FCU_XO_I2D: decode = (ins[20:16] == 5'h00) ? FCU_OP_I2D : FCU_OP_NONE;
        `FCU_XO_D2I: decode = (ins[20:16] == 5'h00) ? FCU_OP_D2I : FCU_OP_NONE;
        `FCU_XO_CMPO: decode = FCU_OP_CMPO;
        `FCU_XO_CMPU: decode = FCU_OP_CMPU;
        default: decode = FCU_OP_NONE;
      endcase
    end
  endfunction

  // One-hot code of a against b; NaN checked first so exactly one bit is set
  function automatic logic [3:0] compare(input logic [63:0] a, input logic [63:0] b);
    logic lt;
    lt = 1'b0;
    if (fcu_is_nan(a) || fcu_is_nan(b)) begin
      compare = `FCU_CC_UN;
    end else if (a == b || (a[62:0] == 63'h0 && b[62:0] == 63'h0)) begin
      compare = `FCU_CC_EQ;
    end else begin
      if (a[63] != b[63]) begin
        lt = a[63];
      end else begin
        lt = a[63] ? (a[62:0] > b[62:0]) : (a[62:0] < b[62:0]);
      end
      compare = lt ? `FCU_CC_LT : `FCU_CC_GT;
    end
  endfunction

  // --------------------------------------------------------------------------
  // Converters
  // --------------------------------------------------------------------------
  logic [63:0] i2d_res;
  logic        i2d_inx;
  logic        i2d_up;
  logic [63:0] d2i_res;
  logic        d2i_inx;
  logic        d2i_up;
  logic        d2i_inv;
  logic        d2i_snan;

  fcu_i2d u_i2d (
    .int_in     (operand_b),
    .rm         (fp_status_control[`FCU_RM_HI:`FCU_RM_LO]),
    .dbl_out    (i2d_res),
    .inexact    (i2d_inx),
    .rounded_up (i2d_up)
  );

  fcu_d2i u_d2i (
    .dbl_in     (operand_b),
    .rm         (fp_status_control[`FCU_RM_HI:`FCU_RM_LO]),
    .int_out    (d2i_res),
    .inexact    (d2i_inx),
    .rounded_up (d2i_up),
    .invalid    (d2i_inv),
    .snan       (d2i_snan)
  );

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  fcu_state_t  st_reg;
  fcu_state_t  st_next;
  logic        done_reg;
  logic        done_next;
  logic        ill_reg;
  logic        ill_next;
  logic        twe_reg;
  logic        twe_next;
  logic [4:0]  tidx_reg;
  logic [4:0]  tidx_next;
  logic [63:0] tdat_reg;
  logic [63:0] tdat_next;
  logic        cwe_reg;
  logic        cwe_next;
  logic [2:0]  cslot_reg;
  logic [2:0]  cslot_next;
  logic [3:0]  cdat_reg;
  logic [3:0]  cdat_next;
  logic [31:0] stat_reg;
  logic [31:0] stat_next;

  fcu_op_t     op;
  logic        take;
  logic        cmp_nan;
  logic        cmp_snan;
  logic        cmp_qnan;
  logic [3:0]  cc;
  logic [31:0] base;
  logic        rec;

  assign op       = decode(issue_instr);
  assign take     = (st_reg == FCU_IDLE) && issue_valid;
  assign cmp_nan  = fcu_is_nan(operand_a) || fcu_is_nan(operand_b);
  assign cmp_snan = fcu_is_snan(operand_a) || fcu_is_snan(operand_b);
  assign cmp_qnan = cmp_nan && !cmp_snan;
  assign cc       = compare(operand_a, operand_b);

  // Next values; software write lands first so hardware sets on top win
  always_comb begin
    st_next    = st_reg;
    done_next  = 1'b0;
    ill_next   = 1'b0;
    twe_next   = 1'b0;
    tidx_next  = tidx_reg;
    tdat_next  = tdat_reg;
    cwe_next   = 1'b0;
    cslot_next = cslot_reg;
    cdat_next  = cdat_reg;
    rec        = 1'b0;
    base       = status_wr ? status_wr_data : stat_reg;
    stat_next  = base;
    unique case (st_reg)
      FCU_IDLE: begin
        if (issue_valid) begin
          st_next   = FCU_HOLD;
          done_next = 1'b1;
          unique case (op)
            FCU_OP_I2D, FCU_OP_D2I: begin
              if (!IMPL_64) begin
                ill_next = 1'b1;
              end else begin
                twe_next  = 1'b1;
                tidx_next = issue_instr[25:21];
                rec       = issue_instr[0];
                if (op == FCU_OP_I2D) begin
                  tdat_next = i2d_res;
                  stat_next[`FCU_FR] = i2d_up;
                  stat_next[`FCU_FI] = i2d_inx;
                  stat_next[`FCU_CLS_HI:`FCU_CLS_LO] = (i2d_res[62:0] == 63'h0) ? `FCU_CLS_PZERO :
                                                       i2d_res[63] ? `FCU_CLS_NNORM : `FCU_CLS_PNORM;
                  if (i2d_inx) begin
                    stat_next[`FCU_XX] = 1'b1;
                  end
                end else begin
                  // Class field is left as it was; its content is undefined here
                  tdat_next = d2i_res;
                  stat_next[`FCU_FR] = d2i_up;
                  stat_next[`FCU_FI] = d2i_inx;
                  if (d2i_inx) begin
                    stat_next[`FCU_XX] = 1'b1;
                  end
                  if (d2i_snan) begin
                    stat_next[`FCU_VXSN] = 1'b1;
                  end
                  if (d2i_inv) begin
                    stat_next[`FCU_INVALID_CONVERSION] = 1'b1;
                  end
                end
              end
            end
            FCU_OP_CMPO, FCU_OP_CMPU: begin
              stat_next[`FCU_CC_HI:`FCU_CC_LO] = cc;
              cwe_next   = 1'b1;
              cslot_next = issue_instr[25:23];
              cdat_next  = cc;
              if (cmp_snan) begin
                stat_next[`FCU_VXSN] = 1'b1;
              end
              // Unordered form leaves the invalid-compare bit alone
              if (op == FCU_OP_CMPO && ((cmp_snan && !base[`FCU_VE]) || cmp_qnan)) begin
                stat_next[`FCU_INVALID_COMPARE] = 1'b1;
              end
            end
            default: begin
              ill_next = 1'b1;
            end
          endcase
        end
      end
      FCU_HOLD: begin
        if (!issue_valid) begin
          st_next = FCU_IDLE;
        end
      end
    endcase
    // Summaries follow the individual bits; new exceptions raise the overall flag
    stat_next[`FCU_VX]  = |(stat_next & `FCU_VX_MASK);
    stat_next[`FCU_FEX] = (stat_next[`FCU_VX] & stat_next[`FCU_VE]) | (stat_next[`FCU_OX] & stat_next[`FCU_OE]) |
                          (stat_next[`FCU_UX] & stat_next[`FCU_UE]) | (stat_next[`FCU_ZX] & stat_next[`FCU_ZE]) |
                          (stat_next[`FCU_XX] & stat_next[`FCU_XE]);
    if ((stat_next & ~base & `FCU_EXC_MASK) != 32'h0) begin
      stat_next[`FCU_FX] = 1'b1;
    end
    if (rec) begin
      cwe_next   = 1'b1;
      cslot_next = `FCU_CR_REC;
      cdat_next  = {stat_next[`FCU_FX], stat_next[`FCU_FEX], stat_next[`FCU_VX], stat_next[`FCU_OX]};
    end
  end

  // Registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_reg    <= FCU_IDLE;
      done_reg  <= 1'b0;
      ill_reg   <= 1'b0;
      twe_reg   <= 1'b0;
      tidx_reg  <= 5'h00;
      tdat_reg  <= 64'h0;
      cwe_reg   <= 1'b0;
      cslot_reg <= 3'h0;
      cdat_reg  <= 4'h0;
      stat_reg  <= `FCU_RST_STATUS;
    end else begin
      st_reg    <= st_next;
      done_reg  <= done_next;
      ill_reg   <= ill_next;
      twe_reg   <= twe_next;
      tidx_reg  <= tidx_next;
      tdat_reg  <= tdat_next;
      cwe_reg   <= cwe_next;
      cslot_reg <= cslot_next;
      cdat_reg  <= cdat_next;
      stat_reg  <= stat_next;
    end
  end

  assign done              = done_reg;
  assign illegal_instr     = ill_reg;
  assign target_we         = twe_reg;
  assign target_index      = tidx_reg;
  assign target_data       = tdat_reg;
  assign cr_we             = cwe_reg;
  assign cr_slot           = cslot_reg;
  assign cr_data           = cdat_reg;
  assign fp_status_control = stat_reg;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  chk_done_once: assert property (@(posedge mclk) disable iff (srst)
    take |=> done ##1 !done) else $error("done is not a single pulse");

  chk_cc_onehot: assert property (@(posedge mclk) disable iff (srst)
    take && (op == FCU_OP_CMPO || op == FCU_OP_CMPU) |=>
    $onehot(fp_status_control[`FCU_CC_HI:`FCU_CC_LO]) && cr_we && cr_data == fp_status_control[`FCU_CC_HI:`FCU_CC_LO]
    && cr_slot == $past(issue_instr[25:23])) else $error("compare code wrong");

  chk_nan_unord: assert property (@(posedge mclk) disable iff (srst)
    take && cmp_nan && (op == FCU_OP_CMPO || op == FCU_OP_CMPU) |=>
    fp_status_control[`FCU_UNORD] && cr_data == `FCU_CC_UN) else $error("NaN compare not unordered");

  // Summary only rises on a fresh flag, so the flag must start clear here
  chk_snan_flag: assert property (@(posedge mclk) disable iff (srst)
    take && cmp_snan && !status_wr && !fp_status_control[`FCU_VXSN] && (op == FCU_OP_CMPO || op == FCU_OP_CMPU) |=>
    fp_status_control[`FCU_VXSN] && fp_status_control[`FCU_FX] && fp_status_control[`FCU_VX])
    else $error("signaling NaN flag missing");

  chk_cmpo_invalid_compare: assert property (@(posedge mclk) disable iff (srst)
    take && op == FCU_OP_CMPO && !status_wr && (cmp_qnan || (cmp_snan && !fp_status_control[`FCU_VE])) |=>
    fp_status_control[`FCU_INVALID_COMPARE]) else $error("invalid compare not set");

  chk_cmpu_novxvc: assert property (@(posedge mclk) disable iff (srst)
    take && op == FCU_OP_CMPU && !status_wr && !fp_status_control[`FCU_INVALID_COMPARE] |=> !fp_status_control[`FCU_INVALID_COMPARE])
    else $error("unordered compare set invalid compare");

  chk_conv_gate: assert property (@(posedge mclk) disable iff (srst)
    take && (op == FCU_OP_I2D || op == FCU_OP_D2I) |=> (illegal_instr == !IMPL_64) && (target_we == IMPL_64))
    else $error("conversion gating wrong");

  chk_rec_field: assert property (@(posedge mclk) disable iff (srst)
    take && IMPL_64 && (op == FCU_OP_I2D || op == FCU_OP_D2I) |=> cr_we == $past(issue_instr[0]) &&
    (!cr_we || (cr_slot == `FCU_CR_REC && cr_data == fp_status_control[31:28]))) else $error("record field wrong");

  chk_sat_value: assert property (@(posedge mclk) disable iff (srst)
    take && IMPL_64 && op == FCU_OP_D2I && d2i_inv |=> fp_status_control[`FCU_INVALID_CONVERSION] &&
    (target_data == `FCU_INT_MIN || target_data == `FCU_INT_MAX) && !fp_status_control[`FCU_FI])
    else $error("saturation wrong");

endmodule
`default_nettype wire

// file: verilog/fcu_cfg.svh
/*
  Constants of the convert and compare unit: instruction encodings, status
  field positions, reset values and arithmetic limits.
  Assumes it is included by bare name wherever a constant is needed.
*/
`ifndef FCU_CFG_SVH
`define FCU_CFG_SVH

// ----------------------------------------------------------------------------
// Instruction encodings
// ----------------------------------------------------------------------------
`define FCU_PRIMARY      6'h3F
`define FCU_XO_I2D       10'h34E
`define FCU_XO_D2I       10'h32E
`define FCU_XO_CMPO      10'h020
`define FCU_XO_CMPU      10'h000
`define FCU_CR_REC       3'h1

// ----------------------------------------------------------------------------
// Status register field positions (bit 31 is the most significant)
// ----------------------------------------------------------------------------
`define FCU_FX           31
`define FCU_FEX          30
`define FCU_VX           29
`define FCU_OX           28
`define FCU_UX           27
`define FCU_ZX           26
`define FCU_XX           25
`define FCU_VXSN         24
`define FCU_INVALID_COMPARE         19
`define FCU_FR           18
`define FCU_FI           17
`define FCU_CLS_HI       16
`define FCU_CLS_LO       12
`define FCU_CC_HI        15
`define FCU_CC_LO        12
`define FCU_UNORD        12
`define FCU_INVALID_CONVERSION        8
`define FCU_VE           7
`define FCU_OE           6
`define FCU_UE           5
`define FCU_ZE           4
`define FCU_XE           3
`define FCU_RM_HI        1
`define FCU_RM_LO        0
`define FCU_EXC_MASK     32'h1FF80700
`define FCU_VX_MASK      32'h01F80700
`define FCU_RST_STATUS   32'h00000000

// ----------------------------------------------------------------------------
// Result class codes and arithmetic limits
// ----------------------------------------------------------------------------
`define FCU_CLS_PZERO    5'h02
`define FCU_CLS_PNORM    5'h04
`define FCU_CLS_NNORM    5'h08
`define FCU_CC_LT        4'h8
`define FCU_CC_GT        4'h4
`define FCU_CC_EQ        4'h2
`define FCU_CC_UN        4'h1
`define FCU_INT_MIN      64'h8000000000000000
`define FCU_INT_MAX      64'h7FFFFFFFFFFFFFFF
`define FCU_EXP_MAX      11'h7FF
`define FCU_EXP_I2D      11'h43E
`define FCU_EXP_UNIT     11'h433
`define FCU_RS_CAP       11'h074
`define FCU_LS_MAX       11'h00B

`endif

// file: verilog/fcu_pkg.sv
/*
  Types and shared helpers of the convert and compare unit.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fcu_pkg;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef enum logic {FCU_IDLE = 1'b0, FCU_HOLD = 1'b1} fcu_state_t;
  typedef enum logic [2:0] {FCU_OP_NONE, FCU_OP_I2D, FCU_OP_D2I, FCU_OP_CMPO, FCU_OP_CMPU} fcu_op_t;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Rounding increment; mode 0 nearest even, 1 zero, 2 up, 3 down
  function automatic logic fcu_round_inc(input logic [1:0] rm, input logic sgn,
                                         input logic lsb, input logic g, input logic st);
    unique case (rm)
      2'h0: fcu_round_inc = g & (st | lsb);
      2'h1: fcu_round_inc = 1'b0;
      2'h2: fcu_round_inc = (g | st) & ~sgn;
      2'h3: fcu_round_inc = (g | st) & sgn;
    endcase
  endfunction

  function automatic logic fcu_is_nan(input logic [63:0] x);
    fcu_is_nan = (x[62:52] == 11'h7FF) && (x[51:0] != 52'h0);
  endfunction

  function automatic logic fcu_is_snan(input logic [63:0] x);
    fcu_is_snan = fcu_is_nan(x) && !x[51];
  endfunction

endpackage

// file: verilog/fcu_i2d.sv
/*
  Signed 64-bit integer to double conversion, purely combinational.
  Assumes the caller registers the outputs.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fcu_cfg.svh"

module fcu_i2d (
  input  wire logic [63:0] int_in,
  input  wire logic [1:0]  rm,
  output logic [63:0]      dbl_out,
  output logic             inexact,
  output logic             rounded_up
);
  import fcu_pkg::*;

  // --------------------------------------------------------------------------
  // Leading zero count
  // --------------------------------------------------------------------------
  function automatic logic [5:0] lzc(input logic [63:0] v);
    lzc = 6'h00;
    for (int i = 0; i < 64; i++) begin
      if (v[i]) begin
        lzc = 6'(63 - i);
      end
    end
  endfunction

  logic [63:0] mag;
  logic [5:0]  lz;
  logic [63:0] norm;
  logic        grd;
  logic        stk;
  logic        inc;
  logic [62:0] body;

  // Exact magnitude; the most negative value maps to 2**63 without loss
  always_comb begin
    mag        = int_in[63] ? (~int_in + 64'h1) : int_in;
    lz         = lzc(mag);
    norm       = mag << lz;
    grd        = norm[10];
    stk        = |norm[9:0];
    inc        = fcu_round_inc(rm, int_in[63], norm[11], grd, stk);
    body       = {11'(`FCU_EXP_I2D - {5'h00, lz}), norm[62:11]} + {62'h0, inc};
    dbl_out    = (mag == 64'h0) ? 64'h0 : {int_in[63], body};
    inexact    = grd | stk;
    rounded_up = inc;
  end

endmodule
`default_nettype wire

// file: verilog/fcu_d2i.sv
/*
  Double to signed 64-bit integer conversion with saturation, combinational.
  Assumes the caller registers the outputs.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fcu_cfg.svh"

module fcu_d2i (
  input  wire logic [63:0] dbl_in,
  input  wire logic [1:0]  rm,
  output logic [63:0]      int_out,
  output logic             inexact,
  output logic             rounded_up,
  output logic             invalid,
  output logic             snan
);
  import fcu_pkg::*;

  logic [10:0]  ex;
  logic [52:0]  sig;
  logic [127:0] sh;
  logic [63:0]  ip;
  logic         grd;
  logic         stk;
  logic         big;
  logic         inc;
  logic [64:0]  mag;
  logic         ovf;
  logic         nan;

  // Shift the significand to the binary point; tiny normal values keep a sticky bit, subnormals lose theirs
  always_comb begin
    ex  = dbl_in[62:52];
    sig = {ex != 11'h0, dbl_in[51:0]};
    nan = fcu_is_nan(dbl_in);
    big = 1'b0;
    ip  = 64'h0;
    grd = 1'b0;
    stk = 1'b0;
    sh  = 128'h0;
    if (ex >= `FCU_EXP_UNIT) begin
      big = (ex - `FCU_EXP_UNIT) > `FCU_LS_MAX;
      ip  = {11'h0, sig} << (ex - `FCU_EXP_UNIT);
    end else begin
      sh  = {11'h0, sig, 64'h0} >> (((`FCU_EXP_UNIT - ex) > `FCU_RS_CAP) ? `FCU_RS_CAP : (`FCU_EXP_UNIT - ex));
      ip  = sh[127:64];
      grd = sh[63];
      stk = |sh[62:0];
    end
    inc = fcu_round_inc(rm, dbl_in[63], ip[0], grd, stk);
    mag = {1'b0, ip} + {64'h0, inc};
    // Negative side may reach exactly 2**63
    ovf = big | (dbl_in[63] ? (mag > {1'b0, `FCU_INT_MIN}) : (mag[64] | mag[63]));
    if (nan) begin
      int_out = `FCU_INT_MIN;
    end else if (ovf) begin
      int_out = dbl_in[63] ? `FCU_INT_MIN : `FCU_INT_MAX;
    end else begin
      int_out = dbl_in[63] ? (~mag[63:0] + 64'h1) : mag[63:0];
    end
    invalid    = nan | ovf;
    snan       = fcu_is_snan(dbl_in);
    inexact    = ~invalid & (grd | stk);
    rounded_up = ~invalid & inc;
  end

endmodule
`default_nettype wire

// file: verification/fcu_issue_model.sv
/*
  Issue side model: presents one request, holds it until done, then releases.
  Assumes the bench drives it only through the issue task.
*/
`timescale 1ns/10ps
`default_nettype none

module fcu_issue_model (
  input  wire logic        mclk,
  input  wire logic        done,
  input  wire logic        illegal_instr,
  input  wire logic        target_we,
  input  wire logic        cr_we,
  input  wire logic        alt_illegal,
  output logic             issue_valid,
  output logic [31:0]      issue_instr,
  output logic [63:0]      operand_a,
  output logic [63:0]      operand_b
);
  logic       seen_done;
  logic [3:0] seen_pulses; // {illegal, target_we, cr_we, narrow illegal}

  initial begin
    issue_valid = 1'b0;
    issue_instr = 32'h0;
    operand_a   = 64'h0;
    operand_b   = 64'h0;
  end

  // ----------------------------------------------------------------------
  // Request: changed at falling edges, held one cycle past done
  // ----------------------------------------------------------------------
  task automatic issue(input logic [31:0] instr, input logic [63:0] a, input logic [63:0] b);
    int n;
    @(negedge mclk);
    issue_valid = 1'b1;
    issue_instr = instr;
    operand_a   = a;
    operand_b   = b;
    seen_done   = 1'b0;
    seen_pulses = 4'h0;
    for (n = 0; n < 20 && !seen_done; n++) begin
      @(negedge mclk);
      if (done === 1'b1) begin
        seen_done   = 1'b1;
        seen_pulses = {illegal_instr, target_we, cr_we, alt_illegal};
      end
    end
    @(negedge mclk);
    issue_valid = 1'b0;
    // Released lines show junk so a stale request cannot pass for a live one
    issue_instr = ~issue_instr;
    operand_a   = ~operand_a;
    operand_b   = ~operand_b;
    @(negedge mclk);
  endtask
endmodule

`default_nettype wire

// file: verification/test_fcu_top.sv
/*
  Bench for the convert and compare unit, with a 32-bit build beside it.
  Assumes the issue model in its own file and the shared constants header.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fcu_cfg.svh"

module test_fcu_top;
  localparam logic [63:0] ONE = 64'h3FF0000000000000, TWO = 64'h4000000000000000;
  localparam logic [63:0] QN = 64'h7FF8000000000000, SN = 64'h7FF0000000000001;
  logic        mclk = 1'b0, srst = 1'b1, status_wr = 1'b0, done, illegal_instr, alt_illegal;
  logic        issue_valid, target_we, cr_we;
  logic [31:0] issue_instr, fp_status_control, status_wr_data = 32'h0;
  logic [63:0] operand_a, operand_b, target_data;
  logic [4:0]  target_index;
  logic [2:0]  cr_slot;
  logic [3:0]  cr_data;
  int          num_errors = 0, checked = 0, cycles = 0;
  // Compare table: {invalid enable, unordered form, code, invalid compare, signaling NaN}
  logic [63:0] cmp_a [7] = '{ONE, TWO, TWO, QN, SN, ONE, SN};
  logic [63:0] cmp_b [7] = '{TWO, ONE, TWO, ONE, ONE, SN, ONE};
  logic [7:0]  cmp_x [7] = '{8'h20, 8'h50, 8'h08, 8'h06, 8'h45, 8'h07, 8'h85};

  always #2 mclk = ~mclk;

  // ----------------------------------------------------------------------
  // Units under test and issue model
  // ----------------------------------------------------------------------
  fcu_top uut (.mclk(mclk), .srst(srst), .issue_valid(issue_valid), .issue_instr(issue_instr),
    .operand_a(operand_a), .operand_b(operand_b), .status_wr(status_wr), .status_wr_data(status_wr_data),
    .done(done), .illegal_instr(illegal_instr), .target_we(target_we), .target_index(target_index),
    .target_data(target_data), .cr_we(cr_we), .cr_slot(cr_slot), .cr_data(cr_data),
    .fp_status_control(fp_status_control));
  // Narrow build shares every input; only its refusal is watched
  fcu_top #(.IMPL_64(1'b0)) uut32 (.mclk(mclk), .srst(srst), .issue_valid(issue_valid),
    .issue_instr(issue_instr), .operand_a(operand_a), .operand_b(operand_b), .status_wr(status_wr),
    .status_wr_data(status_wr_data), .done(), .illegal_instr(alt_illegal), .target_we(), .target_index(),
    .target_data(), .cr_we(), .cr_slot(), .cr_data(), .fp_status_control());
  fcu_issue_model m (.mclk(mclk), .done(done), .illegal_instr(illegal_instr), .target_we(target_we),
    .cr_we(cr_we), .alt_illegal(alt_illegal), .issue_valid(issue_valid), .issue_instr(issue_instr),
    .operand_a(operand_a), .operand_b(operand_b));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks=%0d errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Whole status write; clears stale flags, sets enables and rounding mode
  task automatic clr(input logic [31:0] v);
    @(negedge mclk);
    status_wr      = 1'b1;
    status_wr_data = v;
    @(negedge mclk);
    status_wr = 1'b0;
  endtask

  task automatic go(input logic [9:0] xo, input logic [4:0] t, input logic rec, input logic [4:0] mid,
                    input logic [63:0] a, input logic [63:0] b);
    m.issue({6'h3F, t, mid, 5'h0, xo, rec}, a, b);
    check(m.seen_done, 1'b1);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic test_i2d();
    clr(32'h0);
    go(`FCU_XO_I2D, 5'h3, 1'b0, 5'h0, 64'h0, 64'h1);
    check(target_data, ONE);
    check(target_index, 5'h3);
    check(fp_status_control, 32'h00004000);
    check(m.seen_pulses, 4'h5);
    // Tie at 2**53+1 rounds to even: inexact but not incremented
    go(`FCU_XO_I2D, 5'h4, 1'b1, 5'h0, 64'h0, 64'h0020000000000001);
    check(target_data, 64'h4340000000000000);
    check(fp_status_control, 32'h82024000);
    check({cr_slot, cr_data}, 7'h18);
    check(m.seen_pulses, 4'h7);
    // Negative tie with odd last bit rounds up: increment and negative class
    go(`FCU_XO_I2D, 5'h9, 1'b0, 5'h0, 64'h0, 64'hFFDFFFFFFFFFFFFD);
    check(target_data, 64'hC340000000000002);
    check(fp_status_control, 32'h82068000);
    $display("test i2d finished");
  endtask

  task automatic test_d2i();
    clr(32'h0);
    go(`FCU_XO_D2I, 5'h5, 1'b0, 5'h0, 64'h0, 64'h3FF8000000000000);
    check(target_data, 64'h2);
    check(fp_status_control, 32'h82060000);
    go(`FCU_XO_D2I, 5'h6, 1'b0, 5'h0, 64'h0, 64'h43E0000000000000);
    check(target_data, `FCU_INT_MAX);
    check(fp_status_control[`FCU_INVALID_CONVERSION], 1'b1);
    go(`FCU_XO_D2I, 5'h7, 1'b0, 5'h0, 64'h0, 64'hC3F0000000000000);
    check(target_data, `FCU_INT_MIN);
    go(`FCU_XO_D2I, 5'h8, 1'b0, 5'h1, 64'h0, ONE);
    check(m.seen_pulses, 4'h9);
    // Toward minus infinity: -1.5 becomes -2 and reports the increment
    clr(32'h00000003);
    go(`FCU_XO_D2I, 5'h9, 1'b1, 5'h0, 64'h0, 64'hBFF8000000000000);
    check(target_data, 64'hFFFFFFFFFFFFFFFE);
    check(fp_status_control, 32'h82060003);
    check({cr_slot, cr_data}, 7'h18);
    $display("test d2i finished");
  endtask

  task automatic test_cmp();
    for (int i = 0; i < 7; i++) begin
      clr({24'h0, cmp_x[i][7], 7'h0});
      go(cmp_x[i][6] ? `FCU_XO_CMPU : `FCU_XO_CMPO, {i[2:0], 2'b11}, 1'b1, 5'h0, cmp_a[i], cmp_b[i]);
      check({cr_slot, cr_data}, {i[2:0], cmp_x[i][5:2]});
      check(fp_status_control[15:12], cmp_x[i][5:2]);
      check({fp_status_control[19], fp_status_control[24]}, cmp_x[i][1:0]);
      check(m.seen_pulses, 4'h2);
    end
    $display("test compare finished");
  endtask

  // ----------------------------------------------------------------------
  // Sequence and hang guard
  // ----------------------------------------------------------------------
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      complete_run();
    end
  end

  initial begin
    repeat (12) @(negedge mclk);
    srst = 1'b0;
    check(fp_status_control, 32'h0);
    test_i2d();
    test_d2i();
    test_cmp();
    complete_run();
  end
endmodule

`default_nettype wire
